// *** hw/logic_cell_arith_ram.sv ***
`timescale 1ns/1ns
`default_nettype none
module logic_cell_arith_ram
  import logic_cell_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  input  wire logic      clkEn,
  input  wire cellMode_e mode,
  input  wire arithIn_s  arith,
  input  wire ramIn_s    ram,
  output logic           carryOut,
  output logic           resultDirect,
  output logic           resultReg,
  output logic           ramDirect
);

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  logic isPreloadMode;
  logic isRam16Mode;
  logic isRam32Mode;
  logic isRamMode;

  // Group flags; the two unnamed codes fall into no group and never write
  always_comb begin
    isPreloadMode = (mode == MODE_PRELOAD_ADD) || (mode == MODE_PRELOAD_SUB);
    isRam16Mode   = (mode == MODE_RAM16);
    isRam32Mode   = (mode == MODE_RAM32);
    isRamMode     = isRam16Mode || isRam32Mode;
  end

  // ------------------------------------------------------------
  // Operand selection
  // ------------------------------------------------------------
  logic opA;
  logic opB;

  // Subtract as X + ~Y with the chain carry; lsb cell takes carry in of 1
  always_comb begin
    opA = arith.opX;
    opB = arith.opY;
    case (mode)
      MODE_PRELOAD_ADD: begin
        opB = arith.opY;
      end
      MODE_PRELOAD_SUB: begin
        opB = ~arith.opY;
      end
      MODE_ADDSUB: begin
        opB = arith.opY ^ arith.subtract;
      end
      MODE_MULT: begin
        opA = arith.opX & arith.opY;
        opB = arith.partialInput;
      end
      default: begin
        opB = arith.opY;
      end
    endcase
  end

  // ------------------------------------------------------------
  // One-bit full adder
  // ------------------------------------------------------------
  logic rawSum;
  logic rawCarry;

  // One adder serves every form, so all forms share one carry path
  always_comb begin
    rawSum   = opA ^ opB ^ arith.carryIn;
    rawCarry = (opA & opB) | (opA & arith.carryIn) | (opB & arith.carryIn);
  end

  // ------------------------------------------------------------
  // Preload override
  // ------------------------------------------------------------
  logic sumBit;
  logic carryBit;

  // Carry is cleared on preload so a loaded bit cannot ripple upward
  always_comb begin
    sumBit   = rawSum;
    carryBit = rawCarry;
    if (isPreloadMode && arith.preloadSelect) begin
      sumBit   = arith.preloadValue;
      carryBit = 1'h0;
    end
  end

  // ------------------------------------------------------------
  // Memory: two 16x1 slices, upper address bit picks one in 32-deep mode
  // ------------------------------------------------------------
  logic [1:0] sliceRead;
  logic [1:0] sliceWe;
  logic       ramBit;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gSlice
      // Slice 1 only joins in the 32-deep mode; arithmetic modes never write
      assign sliceWe[gi] = ram.writeStrobe &&
                           ((isRam16Mode && (gi == 0)) ||
                            (isRam32Mode && (ram.addr[RAM32_AW-1] == 1'(gi))));
      ram16x1_slice uSlice (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clkEn    (clkEn),
        .addr     (ram.addr[RAM16_AW-1:0]),
        .writeBit (ram.writeBit),
        .writeEn  (sliceWe[gi]),
        .readBit  (sliceRead[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Combinational read; the upper address bit only steers in 32-deep mode
  always_comb begin
    if (isRam32Mode) begin
      ramBit = sliceRead[ram.addr[RAM32_AW-1]];
    end else begin
      ramBit = sliceRead[0];
    end
  end

  // ------------------------------------------------------------
  // Arithmetic output flops
  // ------------------------------------------------------------
  logic carryOut_q;
  logic carryOut_d;
  logic resultDirect_q;
  logic resultDirect_d;

  // Hold while the clock enable is low; carry feeds the next cell's carry in
  always_comb begin
    carryOut_d     = carryOut_q;
    resultDirect_d = resultDirect_q;
    if (clkEn) begin
      carryOut_d     = carryBit;
      resultDirect_d = sumBit;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      carryOut_q     <= FLOP_RESET;
      resultDirect_q <= FLOP_RESET;
    end else begin
      carryOut_q     <= carryOut_d;
      resultDirect_q <= resultDirect_d;
    end
  end

  // ------------------------------------------------------------
  // Cell flop
  // ------------------------------------------------------------
  logic cellFlop_q;
  logic cellFlop_d;

  // Captures whichever function is active; costs one cycle of latency
  always_comb begin
    cellFlop_d = cellFlop_q;
    if (clkEn) begin
      cellFlop_d = isRamMode ? ramBit : sumBit;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cellFlop_q <= FLOP_RESET;
    end else begin
      cellFlop_q <= cellFlop_d;
    end
  end

  // ------------------------------------------------------------
  // Read output flop
  // ------------------------------------------------------------
  logic ramDirect_q;
  logic ramDirect_d;

  // Samples the pre-edge contents, so a write shows one edge later
  always_comb begin
    ramDirect_d = ramDirect_q;
    if (clkEn) begin
      ramDirect_d = ramBit;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ramDirect_q <= FLOP_RESET;
    end else begin
      ramDirect_q <= ramDirect_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output leaves straight from its flop
  assign carryOut     = carryOut_q;
  assign resultDirect = resultDirect_q;
  assign resultReg    = cellFlop_q;
  assign ramDirect    = ramDirect_q;

endmodule
`default_nettype wire

// *** hw/logic_cell_pkg.sv ***
package logic_cell_pkg;

  // ------------------------------------------------------------
  // Cell modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_PRELOAD_ADD,
    MODE_PRELOAD_SUB,
    MODE_ADDSUB,
    MODE_MULT,
    MODE_RAM16,
    MODE_RAM32
  } cellMode_e;

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int          RAM16_DEPTH = 16;
  localparam int          RAM16_AW    = 4;
  localparam int          RAM32_AW    = 5;
  localparam logic        FLOP_RESET  = 1'h0;
  localparam logic        MEM_RESET   = 1'h0;

  // ------------------------------------------------------------
  // Arithmetic operands and RAM port
  // ------------------------------------------------------------
  typedef struct packed {
    logic opX;
    logic opY;
    logic carryIn;
    logic preloadValue;
    logic preloadSelect;
    logic subtract;
    logic partialInput;
  } arithIn_s;

  typedef struct packed {
    logic [RAM32_AW-1:0] addr;
    logic                writeBit;
    logic                writeStrobe;
  } ramIn_s;

endpackage

// *** hw/ram16x1_slice.sv ***
`timescale 1ns/1ns
`default_nettype none
module ram16x1_slice
  import logic_cell_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                clkEn,
  input  wire logic [RAM16_AW-1:0] addr,
  input  wire logic                writeBit,
  input  wire logic                writeEn,
  output logic                     readBit
);

  logic [RAM16_DEPTH-1:0] mem_q;
  logic [RAM16_DEPTH-1:0] mem_d;

  // Next contents: only the addressed bit changes on a write
  always_comb begin
    mem_d = mem_q;
    if (clkEn && writeEn) begin
      mem_d[addr] = writeBit;
    end
  end

  // Write on the active edge only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_q <= {RAM16_DEPTH{MEM_RESET}};
    end else begin
      mem_q <= mem_d;
    end
  end

  // Read is asynchronous, follows address without a clock
  assign readBit = mem_q[addr];

endmodule
`default_nettype wire

// *** sim/logic_cell_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module logic_cell_sva
  import logic_cell_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      nrst,
  input wire logic      clkEn,
  input wire cellMode_e mode,
  input wire arithIn_s  arith,
  input wire ramIn_s    ram,
  input wire logic      carryOut,
  input wire logic      resultDirect,
  input wire logic      resultReg,
  input wire logic      ramDirect
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Reference sums; subtraction feeds the inverted second operand
  logic [1:0] subS, dirS, mulS;
  assign subS = 2'(arith.opX) + 2'(!arith.opY) + 2'(arith.carryIn);
  assign dirS = 2'(arith.opX) + 2'(arith.opY ^ arith.subtract) + 2'(arith.carryIn);
  assign mulS = 2'(arith.opX & arith.opY) + 2'(arith.partialInput) + 2'(arith.carryIn);
  // Write, hold the address, and expect the new bit after the read edge
  property wrRd(cellMode_e m);
    clkEn && mode == m && ram.writeStrobe ##1 clkEn && mode == m && !ram.writeStrobe && $stable(ram.addr)
      |=> ramDirect == $past(ram.writeBit, 2);
  endproperty
  preload_force_a: assert property (clkEn && mode <= MODE_PRELOAD_SUB && arith.preloadSelect |=>
    resultDirect == $past(arith.preloadValue) && !carryOut) else $error("preload not forced");
  preload_sub_a: assert property (clkEn && mode == MODE_PRELOAD_SUB && !arith.preloadSelect |=>
    {carryOut, resultDirect} == $past(subS)) else $error("subtract result wrong");
  addsub_dir_a: assert property (clkEn && mode == MODE_ADDSUB |=>
    {carryOut, resultDirect} == $past(dirS)) else $error("add/sub result wrong");
  mult_sum_a: assert property (clkEn && mode == MODE_MULT |=>
    {carryOut, resultDirect} == $past(mulS)) else $error("multiplier result wrong");
  arith_flop_a: assert property (clkEn && mode < MODE_RAM16 |=> resultReg == resultDirect)
    else $error("flop differs from sum");
  ram_flop_a: assert property (clkEn && mode >= MODE_RAM16 |=> resultReg == ramDirect)
    else $error("flop differs from read");
  hold_state_a: assert property (!clkEn |=> $stable({carryOut, resultDirect, resultReg, ramDirect}))
    else $error("outputs moved while disabled");
  ram16_wr_a: assert property (wrRd(MODE_RAM16)) else $error("ram16 readback wrong");
  ram32_wr_a: assert property (wrRd(MODE_RAM32)) else $error("ram32 readback wrong");
  cover property (clkEn && mode == MODE_MULT);
  cover property (wrRd(MODE_RAM32));
  cover property (clkEn && mode == MODE_PRELOAD_ADD && arith.preloadSelect);
endmodule
bind logic_cell_arith_ram logic_cell_sva chk (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .mode(mode),
  .arith(arith), .ram(ram), .carryOut(carryOut), .resultDirect(resultDirect), .resultReg(resultReg),
  .ramDirect(ramDirect));
`default_nettype wire

// *** sim/fabric_user.sv ***
`timescale 1ns/1ns
`default_nettype none
module fabric_user
  import logic_cell_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reqEn,
  input  wire cellMode_e reqMode,
  input  wire arithIn_s  reqArith,
  input  wire ramIn_s    reqRam,
  output var logic       clkEn,
  output var cellMode_e  mode,
  output var arithIn_s   arith,
  output var ramIn_s     ram
);
  // Launch on the falling edge: half a period of setup before the cell edge
  initial begin
    {clkEn, arith, ram} = '0;
    mode = MODE_RAM16;
    forever @(negedge sys_clk) begin
      clkEn <= reqEn;
      mode  <= reqMode;
      arith <= reqArith;
      ram   <= reqRam;
    end
  end
endmodule
`default_nettype wire

// *** sim/logic_cell_arith_ram_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module logic_cell_arith_ram_test
  import logic_cell_pkg::*;
;
  logic        sys_clk = 1'h0, nrst = 1'h0, reqEn = 1'h0;
  cellMode_e   reqMode = MODE_RAM16, mode;
  arithIn_s    reqArith = '0, arith;
  ramIn_s      reqRam = '0, ram;
  logic        clkEn, carryOut, resultDirect, resultReg, ramDirect;
  logic [7:0]  noteQ[$], note, last = 8'h0F;
  logic [3:0]  seen;
  logic [31:0] shadowMem = '0;
  int          fails = 0, num_checks = 0;
  always #25 sys_clk = ~sys_clk;
  fabric_user fab (.sys_clk(sys_clk), .reqEn(reqEn), .reqMode(reqMode), .reqArith(reqArith), .reqRam(reqRam),
    .clkEn(clkEn), .mode(mode), .arith(arith), .ram(ram));
  logic_cell_arith_ram dut (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .mode(mode), .arith(arith),
    .ram(ram), .carryOut(carryOut), .resultDirect(resultDirect), .resultReg(resultReg), .ramDirect(ramDirect));
  // Expected carry and sum; preload wins only in the preload modes
  function automatic logic [1:0] arithSum(cellMode_e m, arithIn_s a);
    logic sub;
    sub = (m == MODE_PRELOAD_SUB) || (m == MODE_ADDSUB && a.subtract);
    if (m <= MODE_PRELOAD_SUB && a.preloadSelect) return {1'h0, a.preloadValue};
    if (m == MODE_MULT) return 2'(a.opX & a.opY) + 2'(a.partialInput) + 2'(a.carryIn);
    return 2'(a.opX) + 2'(a.opY ^ sub) + 2'(a.carryIn);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor: oldest note belongs to the edge that has just landed
  always @(posedge sys_clk) begin
    #2;
    if (noteQ.size() > 1) begin
      note = noteQ.pop_front();
      seen = {carryOut, resultDirect, resultReg, ramDirect};
      num_checks++;
      if (((seen ^ note[7:4]) & note[3:0] & 4'hC) !== 4'h0) begin
        fails++;
        $display("[ERR] carryOut,resultDirect expected %h seen %h", note[7:6], seen[3:2]);
      end
      if (((seen ^ note[7:4]) & note[3:0] & 4'h3) !== 4'h0) begin
        fails++;
        $display("[ERR] resultReg,ramDirect expected %h seen %h", note[5:4], seen[1:0]);
      end
    end
  end
  // Driver: random traffic, address often kept so writes are read back
  initial begin
    logic [1:0] s;
    void'($urandom(81));
    repeat (12) @(negedge sys_clk);
    nrst <= 1'h1;
    num_checks++;
    if ({carryOut, resultDirect, resultReg, ramDirect} !== 4'h0) begin
      fails++;
      $display("[ERR] reset outputs expected 0 seen %h", {carryOut, resultDirect, resultReg, ramDirect});
    end
    repeat (1500) begin
      @(posedge sys_clk);
      #1;
      reqEn = ($urandom % 5) != 0;
      reqMode = cellMode_e'($urandom % 6);
      reqArith = 7'($urandom);
      if ($urandom % 3 == 0) reqRam.addr = 5'($urandom);
      reqRam.writeBit = 1'($urandom);
      reqRam.writeStrobe = 1'($urandom);
      if (reqMode == MODE_RAM16) reqRam.addr[4] = 1'h0;
      if (reqEn) begin
        s = arithSum(reqMode, reqArith);
        if (reqMode >= MODE_RAM16) last = {2'h0, {2{shadowMem[reqRam.addr]}}, 4'h3};
        else last = {s, s[0], 1'h0, 4'hE};
        if (reqMode >= MODE_RAM16 && reqRam.writeStrobe) shadowMem[reqRam.addr] = reqRam.writeBit;
      end
      noteQ.push_back(last);
    end
    repeat (2) @(posedge sys_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
